/* File: dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import wwd_pkg::*;
  logic              clock, rst_n, reset_out_n, irq, avs_read, avs_write, avs_waitrequest;
  logic              trigger_in, mode_in, supervisor_disable_n;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0]       avs_writedata, avs_readdata, rd;
  int                mismatches, samples_checked, n;
  wwd_top #(.BASE_CYCLES(2000), .TRIG_MAX_CYC(2000), .SYNC_MULT(4)) i_dut (
    .clock(clock), .rst_n(rst_n), .trigger_in(trigger_in), .mode_in(mode_in),
    .supervisor_disable_n(supervisor_disable_n), .reset_out_n(reset_out_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  wwd_mcu_model i_mcu (.clock(clock), .reset_out_n(reset_out_n), .trigger_in(trigger_in),
    .mode_in(mode_in), .supervisor_disable_n(supervisor_disable_n));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ****
  // Shared tasks
  // ****
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task in_range(input string nm, input int lo, input int hi);
    chk(nm, 32'(n >= lo && n <= hi), 32'h1);
  endtask
  task bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (k >= 20) begin
      mismatches++;
      report_and_stop;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wait_rst(input logic lvl, input int lim);
    n = 0;
    while (reset_out_n !== lvl) begin
      if (n >= lim) begin
        mismatches++;
        report_and_stop;
      end
      @(posedge clock);
      n++;
    end
  endtask
  task high_after(input string nm);
    repeat (20) @(posedge clock);
    chk(nm, 32'(reset_out_n), 32'h1);
  endtask
  task sync_up;
    i_mcu.pulse(100, 1300);
    high_after("sync_ok");
  endtask
  task bounce(input string nm);
    wait_rst(1'b0, 30);
    in_range(nm, 0, 15);
    wait_rst(1'b1, 3000);
  endtask
  // ****
  // Scenarios
  // ****
  task t_sync_irq;
    bus(1'b0, REG_IRQ_ENABLE, 32'h0);
    chk("irq_en_rst", rd, {28'h0000000, IRQ_EN_RST});
    bus(1'b0, REG_CTRL, 32'h0);
    chk("ctrl_rst", rd, 32'h1);
    wait_rst(1'b0, 9000);
    in_range("sync_to", 7980, 8010);
    chk("irq_masked", 32'(irq), 32'h0);
    wait_rst(1'b1, 3000);
    in_range("rst_w", 1995, 2010);
    bus(1'b0, REG_IRQ_STATUS, 32'h0);
    chk("st_to", 32'(rd[IRQ_TIMEOUT_BIT]), 32'h1);
    bus(1'b1, REG_IRQ_ENABLE, 32'h1);
    @(posedge clock);
    chk("irq_on", 32'(irq), 32'h1);
    bus(1'b1, REG_IRQ_CLEAR, 32'h1);
    @(posedge clock);
    chk("irq_clr", 32'(irq), 32'h0);
    bus(1'b0, 5'h1c, 32'h0);
    chk("unmapped", rd, 32'h0);
  endtask
  task t_short;
    sync_up();
    bus(1'b0, REG_STATUS, 32'h0);
    chk("st_closed", 32'(rd[6:0]), 32'h4);
    i_mcu.pulse(1680, 1300);
    high_after("open1");
    i_mcu.pulse(1680, 1300);
    high_after("open2");
    wait_rst(1'b0, 5000);
    in_range("short_to", 3975, 4000);
    wait_rst(1'b1, 3000);
    sync_up();
    i_mcu.pulse(180, 1300);
    bounce("short_early");
    bus(1'b0, REG_IRQ_STATUS, 32'h0);
    chk("st_early", 32'(rd[IRQ_EARLY_BIT]), 32'h1);
    chk("st_service", 32'(rd[IRQ_SERVICE_BIT]), 32'h1);
  endtask
  task t_long;
    i_mcu.drive(1'b1, 1'b1, 1'b1);
    sync_up();
    i_mcu.pulse(1680, 1300);
    bounce("long_early");
    sync_up();
    wait_rst(1'b0, 17000);
    in_range("long_to", 15975, 16000);
    wait_rst(1'b1, 3000);
  endtask
  task t_switch;
    i_mcu.drive(1'b1, 1'b0, 1'b1);
    sync_up();
    i_mcu.drive(1'b1, 1'b1, 1'b1);
    i_mcu.pulse(1680, 1300);
    bounce("to_long");
    sync_up();
    i_mcu.drive(1'b1, 1'b0, 1'b1);
    i_mcu.pulse(1680, 1300);
    high_after("to_short");
    wait_rst(1'b0, 5000);
    wait_rst(1'b1, 3000);
  endtask
  task t_err_dis;
    i_mcu.drive(1'b0, 1'b0, 1'b1);
    repeat (2300) @(posedge clock);
    chk("stuck", 32'(reset_out_n), 32'h0);
    i_mcu.drive(1'b1, 1'b0, 1'b1);
    wait_rst(1'b1, 20);
    in_range("stuck_rel", 0, 12);
    bus(1'b0, REG_IRQ_STATUS, 32'h0);
    chk("st_terr", 32'(rd[IRQ_TERR_BIT]), 32'h1);
    i_mcu.drive(1'b1, 1'b0, 1'b0);
    repeat (10) @(posedge clock);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("st_off", 32'(rd[6:0]), 32'h40);
    n = 0;
    repeat (8500) begin
      @(posedge clock);
      if (reset_out_n !== 1'b1) n++;
    end
    chk("dis_quiet", 32'(n), 32'h0);
    bus(1'b1, REG_CTRL, 32'h0);
    i_mcu.drive(1'b1, 1'b0, 1'b1);
    repeat (10) @(posedge clock);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("sw_off", 32'(rd[6:0]), 32'h40);
    bus(1'b1, REG_CTRL, 32'h1);
  endtask
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = 32'h0;
    repeat (4) @(posedge clock);
    chk("rst_low", 32'(reset_out_n), 32'h0);
    rst_n <= 1'b1;
    wait_rst(1'b1, 5000);
    in_range("hold", 4000, 4012);
    t_sync_irq();
    t_short();
    t_long();
    t_switch();
    t_err_dis();
    report_and_stop();
  end
endmodule

/* File: dv/wwd_checker_asserts.sv */
`timescale 1ns/100ps
module wwd_checker_asserts
  import wwd_pkg::*;
#(
  parameter int BASE_CYCLES  = 2000,
  parameter int TRIG_MAX_CYC = 2000,
  parameter int RSTW_MULT    = 1
)(
  // Clock and reset
  input wire logic                       clock,
  input wire logic                       rst_n,
  // Watchdog pins
  input wire logic                       trigger_in,
  input wire logic                       mode_in,
  input wire logic                       supervisor_disable_n,
  input wire logic                       reset_out_n,
  // Avalon-MM slave
  input wire logic [wwd_pkg::ADDR_W-1:0] avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [31:0]                avs_writedata,
  input wire logic [3:0]                 avs_byteenable,
  input wire logic [31:0]                avs_readdata,
  input wire logic                       avs_waitrequest,
  // Interrupt
  input wire logic                       irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ****
  // Helper counters
  // ****
  logic [15:0] low_cnt_r, low_cnt_nxt, low_run_r, low_run_nxt;
  logic        err_r, err_nxt;
  always_comb begin
    low_cnt_nxt = trigger_in ? 16'h0000 : low_cnt_r + {15'h0000, low_cnt_r != 16'hffff};
    low_run_nxt = reset_out_n ? 16'h0000 : low_run_r + {15'h0000, low_run_r != 16'hffff};
    err_nxt = err_r;
    if (int'(low_cnt_r) > TRIG_MAX_CYC) begin
      err_nxt = 1'b1;
    end else if (reset_out_n && trigger_in) begin
      err_nxt = 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_r <= 16'h0000;
      low_run_r <= 16'h0000;
      err_r     <= 1'b0;
    end else begin
      low_cnt_r <= low_cnt_nxt;
      low_run_r <= low_run_nxt;
      err_r     <= err_nxt;
    end
  end
  // ****
  // Properties
  // ****
  sequence s_answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence s_hold_low;
    (!reset_out_n) [*8];
  endsequence
  property p_hold_start; $rose(rst_n) |-> s_hold_low; endproperty
  property p_irq_quiet; $rose(rst_n) |-> !irq; endproperty
  property p_wait_rd; $rose(avs_read) |-> s_answer; endproperty
  property p_wait_wr; $rose(avs_write) |-> s_answer; endproperty
  property p_unmapped;
    avs_read && !avs_waitrequest && (avs_address == REG_IRQ_CLEAR || avs_address > REG_COUNT)
      |-> avs_readdata == 32'h00000000;
  endproperty
  property p_disable; (!supervisor_disable_n && reset_out_n) [*4] |=> reset_out_n; endproperty
  property p_err_hold;
    supervisor_disable_n && int'(low_cnt_r) > TRIG_MAX_CYC + 6 |-> !reset_out_n;
  endproperty
  property p_err_release; $rose(trigger_in) && err_r |-> ##[1:10] reset_out_n; endproperty
  property p_rst_width;
    $rose(reset_out_n) && !err_r && supervisor_disable_n
      |-> int'(low_run_r) >= RSTW_MULT * BASE_CYCLES - 2;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("reset out rose early");
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq high after reset");
  a_wait_rd: assert property (p_wait_rd) else $error("read answer timing wrong");
  a_wait_wr: assert property (p_wait_wr) else $error("write answer timing wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_disable: assert property (p_disable) else $error("reset issued while disabled");
  a_err_hold: assert property (p_err_hold) else $error("stuck trigger not holding reset");
  a_err_release: assert property (p_err_release) else $error("reset not freed");
  a_rst_width: assert property (p_rst_width) else $error("reset pulse too short");
endmodule

bind wwd_top wwd_checker_asserts #(
  .BASE_CYCLES(BASE_CYCLES), .TRIG_MAX_CYC(TRIG_MAX_CYC), .RSTW_MULT(RSTW_MULT)
) i_chk (
  .clock(clock), .rst_n(rst_n), .trigger_in(trigger_in), .mode_in(mode_in),
  .supervisor_disable_n(supervisor_disable_n), .reset_out_n(reset_out_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq)
);

/* File: dv/wwd_mcu_model.sv */
`timescale 1ns/100ps
module wwd_mcu_model
  import wwd_pkg::*;
(
  // Clock and reset from the supervisor
  input wire logic clock,
  input wire logic reset_out_n,
  // Pins toward the supervisor
  output logic     trigger_in,
  output logic     mode_in,
  output logic     supervisor_disable_n
);
  initial begin
    trigger_in = 1'b1;
    mode_in = 1'b0;
    supervisor_disable_n = 1'b1;
  end
  // Low pulse after an idle gap; width raised to at least the legal minimum, no upper limit applied
  task pulse(input int gap, input int width);
    if (width < TRIG_MIN_CYC) width = TRIG_MIN_CYC;
    repeat (gap) @(posedge clock);
    trigger_in <= 1'b0;
    repeat (width) @(posedge clock);
    trigger_in <= 1'b1;
  endtask
  // Static levels; a low trigger here may break the width band on purpose
  task drive(input logic t, input logic m, input logic e);
    @(posedge clock);
    trigger_in <= t;
    mode_in <= m;
    supervisor_disable_n <= e;
  endtask
endmodule

/* File: pkg/wwd_pkg.sv */
package wwd_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_PERIOD_NS     = 8;
  localparam int TRIG_MIN_NS       = 10000;
  localparam int TRIG_MAX_NS       = 5000000;
  localparam int TRIG_MIN_CYC      = (TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIG_MAX_CYC      = TRIG_MAX_NS / CLK_PERIOD_NS;

  // Base period: slope per kilohm of the setting resistor plus an offset
  localparam int TIMER_SLOPE_PS_PER_KOHM = 15750000;
  localparam int TIMER_OFFSET_PS         = 73500000;
  localparam int TIMER_RES_KOHM          = 51;
  localparam int BASE_PERIOD_NS    = (TIMER_SLOPE_PS_PER_KOHM / 1000) * TIMER_RES_KOHM
                                     + TIMER_OFFSET_PS / 1000;
  localparam int BASE_CYCLES       = BASE_PERIOD_NS / CLK_PERIOD_NS;

  // Interval lengths in base periods
  localparam int HOLD_MULT         = 2;
  localparam int SYNC_MULT         = 8;
  localparam int SCLOSED_MULT      = 1;
  localparam int SOPEN_MULT        = 1;
  localparam int LCLOSED_MULT      = 4;
  localparam int LOPEN_MULT        = 4;
  localparam int RSTW_MULT         = 1;
  localparam int CNT_W             = 16;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int ADDR_W            = 5;
  localparam logic [4:0] REG_CTRL       = 5'h00;
  localparam logic [4:0] REG_STATUS     = 5'h04;
  localparam logic [4:0] REG_IRQ_STATUS = 5'h08;
  localparam logic [4:0] REG_IRQ_ENABLE = 5'h0c;
  localparam logic [4:0] REG_IRQ_CLEAR  = 5'h10;
  localparam logic [4:0] REG_COUNT      = 5'h14;

  localparam int CTRL_EN_BIT       = 0;
  localparam logic CTRL_EN_RST     = 1'b1;
  localparam int ST_STATE_LSB      = 0;
  localparam int ST_RSTOUT_BIT     = 8;
  localparam int ST_MODE_BIT       = 9;
  localparam int ST_ENABLE_BIT     = 10;
  localparam int ST_TERR_BIT       = 11;

  localparam int IRQ_W             = 4;
  localparam int IRQ_TIMEOUT_BIT   = 0;
  localparam int IRQ_EARLY_BIT     = 1;
  localparam int IRQ_TERR_BIT      = 2;
  localparam int IRQ_SERVICE_BIT   = 3;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;

  // ************************************************************
  // Supervisor states
  // ************************************************************
  typedef enum logic [6:0] {
    WWD_HOLD   = 7'h01,
    WWD_SYNC   = 7'h02,
    WWD_CLOSED = 7'h04,
    WWD_OPEN   = 7'h08,
    WWD_RST    = 7'h10,
    WWD_ERR    = 7'h20,
    WWD_OFF    = 7'h40
  } wwd_state_t;

endpackage

/* File: pkg/wwd_trig_if.sv */
`timescale 1ns/100ps
interface wwd_trig_if;
  logic valid_trigger_pulse;
  logic trig_error;
  logic mode_sync;
  logic enable_sync;

  modport src (
    output valid_trigger_pulse,
    output trig_error,
    output mode_sync,
    output enable_sync
  );

  modport dst (
    input  valid_trigger_pulse,
    input  trig_error,
    input  mode_sync,
    input  enable_sync
  );
endinterface

/* File: src/wwd_top.sv */
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
// What this block does
// - Reset output is low from the moment supply-good reset is applied.
// - After reset release, hold reset output low one hold time, then sync monitoring.
// - All intervals derive from a base period set by a resistor-derived parameter.
// - Valid trigger during sync interval restarts timer and enters windowed operation.
// - No valid trigger within sync interval gives reset pulse, back to sync.
// - Mode low: short windows; trigger in short closed window gives reset pulse.
// - Trigger in open window is good service and restarts the closed window.
// - Short mode: no trigger within closed plus open gives reset pulse.
// - Mode high: long windows; trigger in long closed window gives reset pulse.
// - Long mode: no trigger within closed plus open gives reset pulse.
// - Mode rising during short windows switches to long timing.
// - Mode falling during long windows switches to short timing.
// - Disable input low stops supervision; high enables it only while the CTRL enable bit is set.
// - Trigger low beyond maximum width holds reset low until trigger returns high.
module wwd_top #(
  parameter int BASE_CYCLES  = wwd_pkg::BASE_CYCLES,
  parameter int TRIG_MAX_CYC = wwd_pkg::TRIG_MAX_CYC,
  parameter int HOLD_MULT    = wwd_pkg::HOLD_MULT,
  parameter int SYNC_MULT    = wwd_pkg::SYNC_MULT,
  parameter int SCLOSED_MULT = wwd_pkg::SCLOSED_MULT,
  parameter int SOPEN_MULT   = wwd_pkg::SOPEN_MULT,
  parameter int LCLOSED_MULT = wwd_pkg::LCLOSED_MULT,
  parameter int LOPEN_MULT   = wwd_pkg::LOPEN_MULT,
  parameter int RSTW_MULT    = wwd_pkg::RSTW_MULT
)(
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  // Watchdog pins
  input  wire logic                       trigger_in,
  input  wire logic                       mode_in,
  input  wire logic                       supervisor_disable_n,
  output logic                            reset_out_n,
  // Avalon-MM slave
  input  wire logic [wwd_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic [31:0]                     avs_readdata,
  output logic                            avs_waitrequest,
  // Interrupt
  output logic                            irq
);
  import wwd_pkg::*;

  localparam int PRE_W = $clog2(BASE_CYCLES + 1);

  wwd_trig_if  tq ();

  wwd_state_t        state_r;
  wwd_state_t        state_nxt;
  logic [PRE_W-1:0]  pre_r;
  logic [PRE_W-1:0]  pre_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic [CNT_W-1:0]  limit;
  logic              rstout_r;
  logic              rstout_nxt;
  logic              tick;
  logic              expire;
  logic              restart;
  logic              restart_req;
  logic              enabled;
  logic              ev_timeout;
  logic              ev_early;
  logic              ev_terr;
  logic              ev_service;

  logic              ctrl_en_r;
  logic              ctrl_en_nxt;
  logic [IRQ_W-1:0]  irq_st_r;
  logic [IRQ_W-1:0]  irq_st_nxt;
  logic [IRQ_W-1:0]  irq_en_r;
  logic [IRQ_W-1:0]  irq_en_nxt;
  logic [IRQ_W-1:0]  irq_clr;
  logic [IRQ_W-1:0]  events;
  logic              ack_r;
  logic              ack_nxt;
  logic [31:0]       rdata_r;
  logic [31:0]       rdata_nxt;
  logic [31:0]       rd_mux;
  logic              req;
  logic              wr_fire;

  // ************************************************************
  // Trigger qualification and input synchronisers
  // ************************************************************
  wwd_trig_qual #(
    .MIN_CYC              (TRIG_MIN_CYC),
    .MAX_CYC              (TRIG_MAX_CYC)
  ) u_qual (
    .clock                (clock),
    .rst_n                (rst_n),
    .trigger_in           (trigger_in),
    .mode_in              (mode_in),
    .supervisor_disable_n (supervisor_disable_n),
    .qual                 (tq.src)
  );

  assign enabled = tq.enable_sync && ctrl_en_r;

  // ************************************************************
  // Base-period time base and interval counter
  // ************************************************************
  assign tick = (pre_r == PRE_W'(BASE_CYCLES - 1));

  // Window lengths follow the live mode level, so a change takes effect at once
  always_comb begin
    case (state_r)
      WWD_HOLD:   limit = CNT_W'(HOLD_MULT);
      WWD_SYNC:   limit = CNT_W'(SYNC_MULT);
      WWD_CLOSED: limit = tq.mode_sync ? CNT_W'(LCLOSED_MULT)
                                       : CNT_W'(SCLOSED_MULT);
      WWD_OPEN:   limit = tq.mode_sync ? CNT_W'(LOPEN_MULT)
                                       : CNT_W'(SOPEN_MULT);
      WWD_RST:    limit = CNT_W'(RSTW_MULT);
      default:    limit = '0;
    endcase
  end

  assign expire = tick && (cnt_r + CNT_W'(1) >= limit);

  always_comb begin
    pre_nxt = pre_r + PRE_W'(1);
    cnt_nxt = cnt_r;
    if (restart) begin
      pre_nxt = '0;
      cnt_nxt = '0;
    end else if (tick) begin
      pre_nxt = '0;
      cnt_nxt = cnt_r + CNT_W'(1);
    end
  end

  // ************************************************************
  // Supervisor state machine
  // ************************************************************
  always_comb begin
    state_nxt   = state_r;
    restart_req = 1'b0;
    ev_timeout  = 1'b0;
    ev_early    = 1'b0;
    ev_terr     = 1'b0;
    ev_service  = 1'b0;
    if (state_r == WWD_HOLD) begin
      if (expire) begin
        state_nxt = enabled ? WWD_SYNC : WWD_OFF;
      end
    end else if (!enabled) begin
      state_nxt = WWD_OFF;
    end else if (tq.trig_error && state_r != WWD_ERR) begin
      // A stuck trigger outranks every window decision
      state_nxt = WWD_ERR;
      ev_terr   = 1'b1;
    end else begin
      case (state_r)
        WWD_SYNC: begin
          if (tq.valid_trigger_pulse) begin
            state_nxt = WWD_CLOSED;
          end else if (expire) begin
            state_nxt  = WWD_RST;
            ev_timeout = 1'b1;
          end
        end
        WWD_CLOSED: begin
          if (tq.valid_trigger_pulse) begin
            state_nxt = WWD_RST;
            ev_early  = 1'b1;
          end else if (expire) begin
            state_nxt = WWD_OPEN;
          end
        end
        WWD_OPEN: begin
          if (tq.valid_trigger_pulse) begin
            state_nxt  = WWD_CLOSED;
            ev_service = 1'b1;
          end else if (expire) begin
            state_nxt  = WWD_RST;
            ev_timeout = 1'b1;
          end
        end
        WWD_RST: begin
          // A trigger during the reset pulse restarts its width
          if (tq.valid_trigger_pulse) begin
            restart_req = 1'b1;
          end else if (expire) begin
            state_nxt = WWD_SYNC;
          end
        end
        WWD_ERR: begin
          if (!tq.trig_error) begin
            state_nxt = WWD_SYNC;
          end
        end
        WWD_OFF: begin
          state_nxt = WWD_SYNC;
        end
        default: begin
          state_nxt = WWD_SYNC;
        end
      endcase
    end
    restart    = restart_req || (state_nxt != state_r);
    rstout_nxt = !((state_nxt == WWD_HOLD) || (state_nxt == WWD_RST) ||
                   (state_nxt == WWD_ERR));
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= WWD_HOLD;
      pre_r    <= '0;
      cnt_r    <= '0;
      rstout_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      pre_r    <= pre_nxt;
      cnt_r    <= cnt_nxt;
      rstout_r <= rstout_nxt;
    end
  end

  assign reset_out_n = rstout_r;

  // ************************************************************
  // Register bus and interrupts
  // ************************************************************
  // Every access takes exactly one wait state
  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_r;
  assign wr_fire         = avs_write && ack_r;

  assign events = {ev_service, ev_terr, ev_early, ev_timeout};

  always_comb begin
    rd_mux = 32'h0;
    case (avs_address)
      REG_CTRL: begin
        rd_mux[CTRL_EN_BIT] = ctrl_en_r;
      end
      REG_STATUS: begin
        rd_mux[ST_STATE_LSB +: 7] = state_r;
        rd_mux[ST_RSTOUT_BIT]     = rstout_r;
        rd_mux[ST_MODE_BIT]       = tq.mode_sync;
        rd_mux[ST_ENABLE_BIT]     = enabled;
        rd_mux[ST_TERR_BIT]       = tq.trig_error;
      end
      REG_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_st_r;
      REG_IRQ_ENABLE: rd_mux[IRQ_W-1:0] = irq_en_r;
      REG_COUNT:      rd_mux[CNT_W-1:0] = cnt_r;
      default:        rd_mux = 32'h0;
    endcase
  end

  always_comb begin
    ack_nxt     = req && !ack_r;
    rdata_nxt   = rdata_r;
    ctrl_en_nxt = ctrl_en_r;
    irq_en_nxt  = irq_en_r;
    irq_clr     = '0;
    if (avs_read && !ack_r) begin
      rdata_nxt = rd_mux;
    end
    if (wr_fire && avs_byteenable[0]) begin
      case (avs_address)
        REG_CTRL:       ctrl_en_nxt = avs_writedata[CTRL_EN_BIT];
        REG_IRQ_ENABLE: irq_en_nxt  = avs_writedata[IRQ_W-1:0];
        REG_IRQ_CLEAR:  irq_clr     = avs_writedata[IRQ_W-1:0];
        default:        ctrl_en_nxt = ctrl_en_r;
      endcase
    end
    // A new event wins over a clear in the same cycle
    irq_st_nxt = (irq_st_r & ~irq_clr) | events;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_r     <= 1'b0;
      rdata_r   <= 32'h0;
      ctrl_en_r <= CTRL_EN_RST;
      irq_en_r  <= IRQ_EN_RST;
      irq_st_r  <= '0;
    end else begin
      ack_r     <= ack_nxt;
      rdata_r   <= rdata_nxt;
      ctrl_en_r <= ctrl_en_nxt;
      irq_en_r  <= irq_en_nxt;
      irq_st_r  <= irq_st_nxt;
    end
  end

  assign avs_readdata = rdata_r;
  assign irq          = |(irq_st_r & irq_en_r);

endmodule

/* File: src/wwd_trig_qual.sv */
`timescale 1ns/100ps
module wwd_trig_qual #(
  parameter int MIN_CYC = wwd_pkg::TRIG_MIN_CYC,
  parameter int MAX_CYC = wwd_pkg::TRIG_MAX_CYC
)(
  // Clock and reset
  input  wire logic   clock,
  input  wire logic   rst_n,
  // Raw pins
  input  wire logic   trigger_in,
  input  wire logic   mode_in,
  input  wire logic   supervisor_disable_n,
  // Qualified trigger toward the supervisor
  wwd_trig_if.src     qual
);
  import wwd_pkg::*;

  localparam int LW = $clog2(MAX_CYC + 2);

  logic [2:0]    raw;
  logic [2:0]    s1_r;
  logic [2:0]    s2_r;
  logic          prev_r;
  logic [LW-1:0] low_r;
  logic [LW-1:0] low_nxt;
  logic          valid_r;
  logic          valid_nxt;
  logic          err_r;
  logic          err_nxt;

  // ************************************************************
  // Two-stage synchronisers
  // ************************************************************
  assign raw = {supervisor_disable_n, mode_in, trigger_in};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          s1_r[g] <= 1'b1;
          s2_r[g] <= 1'b1;
        end else begin
          s1_r[g] <= raw[g];
          s2_r[g] <= s1_r[g];
        end
      end
    end
  endgenerate

  // ************************************************************
  // Low-time measurement
  // ************************************************************
  always_comb begin
    low_nxt   = low_r;
    valid_nxt = 1'b0;
    err_nxt   = 1'b0;
    if (!s2_r[0]) begin
      if (low_r <= LW'(MAX_CYC)) begin
        low_nxt = low_r + LW'(1);
      end
      err_nxt = (low_r >= LW'(MAX_CYC));
    end else begin
      low_nxt   = '0;
      // Rising edge ends a pulse; its width decides validity
      valid_nxt = !prev_r && (low_r >= LW'(MIN_CYC)) && (low_r <= LW'(MAX_CYC));
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_r  <= 1'b1;
      low_r   <= '0;
      valid_r <= 1'b0;
      err_r   <= 1'b0;
    end else begin
      prev_r  <= s2_r[0];
      low_r   <= low_nxt;
      valid_r <= valid_nxt;
      err_r   <= err_nxt;
    end
  end

  assign qual.valid_trigger_pulse = valid_r;
  assign qual.trig_error          = err_r;
  assign qual.mode_sync           = s2_r[1];
  assign qual.enable_sync         = s2_r[2];

endmodule
